// File: verilog/ubrg_consts.svh
`ifndef UBRG_CONSTS_SVH
`define UBRG_CONSTS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define UBRG_ADDR_DIVISOR 12'h000
`define UBRG_ADDR_CONTROL 12'h004
`define UBRG_ADDR_STATUS 12'h008

// ****************************************
// field positions and reset values
// ****************************************
`define UBRG_CTL_HSEL_BIT 2
`define UBRG_CTL_SYNC_BIT 4
`define UBRG_CTL_MASTER_BIT 7
`define UBRG_DIVISOR_RST 8'h00
`define UBRG_CONTROL_RST 3'h0

// ****************************************
// division factors and sampling
// ****************************************
`define UBRG_DIV_ASYNC_LOW 6'h3F
`define UBRG_DIV_ASYNC_HIGH 6'h0F
`define UBRG_DIV_SYNC 6'h03
`define UBRG_OVS_LAST 4'hF
`define UBRG_PRE_QUARTER 2'h3
`define UBRG_SMP_A 4'h6
`define UBRG_SMP_B 4'h7
`define UBRG_SMP_C 4'h8

`endif

// File: verilog/ubrg_pkg.sv
// ****************************************
// shared types
// ****************************************
package ubrg_pkg;
   // mode of the rate generator
   typedef enum logic [1:0] {
      UBRG_ASYNC_LOW,
      UBRG_ASYNC_HIGH,
      UBRG_SYNC,
      UBRG_OFF
   } ubrg_mode_t;
   // control fields as stored
   typedef struct packed {
      logic master;
      logic sync;
      logic hsel;
   } ubrg_ctl_t;
   // tick and sample outputs
   typedef struct packed {
      logic bit_tick;
      logic ovs_tick;
      logic smp_valid;
      logic rx_level;
   } ubrg_out_t;
endpackage

// File: verilog/ubrg_top.sv
`timescale 1ns/100ps
`include "ubrg_consts.svh"

// Contract
// - free-running 8-bit timer, divisor sets period
// - one timer serves async and sync modes
// - high-speed select changes async division
// - sync mode ignores high-speed select
// - async low: fosc over 64(X+1)
// - async high: fosc over 16(X+1)
// - sync: fosc over 4(X+1)
// - rate only when master, internal clock
// - divisor unsigned 0 to 255
// - divisor write restarts timer at once
// - receive pin majority of three samples
// - recovery runs at sixteen times bit in async modes
// - divisor clears to zero on reset
module ubrg_top
   import ubrg_pkg::*;
#(
   parameter int DIV_W = 8
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic receive_data_pin,
   output logic bit_tick,
   output logic ovs_tick,
   output logic smp_valid,
   output logic rx_level
);

   // ****************************************
   // register state
   // ****************************************
   logic [DIV_W-1:0] baud_divisor_r; // divisor X
   ubrg_ctl_t ctl_r; // mode control bits
   logic [DIV_W-1:0] tmr_r; // rate_generator timer
   logic [5:0] pre_r; // mode prescaler
   logic [3:0] ovs_r; // oversample phase
   logic [2:0] smp_r; // three pin samples
   ubrg_out_t out_r; // registered outputs
   ubrg_mode_t mode; // decoded mode
   logic [5:0] pre_last; // prescaler terminal
   logic wr_en; // write access phase
   logic rd_en; // read access phase
   logic div_wr; // divisor written
   logic ctl_wr; // control written
   logic tmr_wrap; // timer period done
   logic pre_wrap; // prescaler period done
   logic run; // generator active
   logic ovs_step; // oversample phase step
   logic [15:0] gap_r; // clocks since last bit tick
   logic gap_ok_r; // no write since last tick
   logic [15:0] gap_fac; // mode factor for spacing
   logic [15:0] gap_exp; // expected tick spacing

   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign div_wr = wr_en & (paddr == `UBRG_ADDR_DIVISOR);
   assign ctl_wr = wr_en & (paddr == `UBRG_ADDR_CONTROL);

   // ****************************************
   // mode decode
   // ****************************************
   // master clock only
   assign run = ctl_r.master;
   // decode mode from control bits
   always_comb begin
      if (!run) begin
         mode = UBRG_OFF;
      end else if (ctl_r.sync) begin
         mode = UBRG_SYNC;
      end else if (ctl_r.hsel) begin
         mode = UBRG_ASYNC_HIGH;
      end else begin
         mode = UBRG_ASYNC_LOW;
      end
   end

   // prescaler terminal per mode
   always_comb begin
      unique case (mode)
         UBRG_ASYNC_LOW: pre_last = `UBRG_DIV_ASYNC_LOW;
         UBRG_ASYNC_HIGH: pre_last = `UBRG_DIV_ASYNC_HIGH;
         UBRG_SYNC: pre_last = `UBRG_DIV_SYNC;
         UBRG_OFF: pre_last = `UBRG_DIV_SYNC;
      endcase
   end

   // ****************************************
   // apb slave
   // ****************************************
   // always ready, error on unmapped address
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & (paddr != `UBRG_ADDR_DIVISOR)
            & (paddr != `UBRG_ADDR_CONTROL) & (paddr != `UBRG_ADDR_STATUS);
      end
   end

   // read data mux, captured in setup
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= 32'h0000_0000;
         // status, divisor, control by address
         if (paddr == `UBRG_ADDR_DIVISOR) begin
            prdata[DIV_W-1:0] <= baud_divisor_r;
         end else if (paddr == `UBRG_ADDR_CONTROL) begin
            prdata[`UBRG_CTL_MASTER_BIT] <= ctl_r.master;
            prdata[`UBRG_CTL_SYNC_BIT] <= ctl_r.sync;
            prdata[`UBRG_CTL_HSEL_BIT] <= ctl_r.hsel;
         end else if (paddr == `UBRG_ADDR_STATUS) begin
            prdata[DIV_W-1:0] <= tmr_r;
            prdata[DIV_W+1:DIV_W] <= mode;
         end
      end
   end

   // divisor register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         baud_divisor_r <= `UBRG_DIVISOR_RST;
      end else if (div_wr && pready) begin
         baud_divisor_r <= pwdata[DIV_W-1:0];
      end
   end

   // control register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctl_r <= ubrg_ctl_t'(`UBRG_CONTROL_RST);
      end else if (ctl_wr && pready) begin
         ctl_r.master <= pwdata[`UBRG_CTL_MASTER_BIT];
         ctl_r.sync <= pwdata[`UBRG_CTL_SYNC_BIT];
         ctl_r.hsel <= pwdata[`UBRG_CTL_HSEL_BIT];
      end
   end

   // ****************************************
   // rate timer and prescaler
   // ****************************************
   assign tmr_wrap = (tmr_r == baud_divisor_r);
   assign pre_wrap = (pre_r == pre_last);
   // sixteen oversample steps per bit in async
   assign ovs_step = tmr_wrap && ((mode == UBRG_ASYNC_HIGH)
      || ((mode == UBRG_ASYNC_LOW) && (pre_r[1:0] == `UBRG_PRE_QUARTER)));

   // timer counts 0..X then reloads
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tmr_r <= '0;
      end else if ((div_wr && pready) || !run) begin
         tmr_r <= '0;
      end else if (tmr_wrap) begin
         tmr_r <= '0;
      end else begin
         tmr_r <= tmr_r + 1'b1;
      end
   end

   // prescaler advances on each timer tick
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pre_r <= '0;
      end else if ((div_wr && pready) || (ctl_wr && pready) || !run) begin
         pre_r <= '0;
      end else if (tmr_wrap) begin
         pre_r <= pre_wrap ? 6'h00 : pre_r + 6'h01;
      end
   end

   // oversample phase, sixteen per bit in async
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ovs_r <= '0;
      end else if ((div_wr && pready) || (ctl_wr && pready) || !run) begin
         ovs_r <= '0;
      end else if (ovs_step) begin
         ovs_r <= ovs_r + 4'h1;
      end
   end

   // ****************************************
   // outputs and majority sampling
   // ****************************************
   // registered tick outputs
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         out_r.bit_tick <= 1'b0;
         out_r.ovs_tick <= 1'b0;
      end else begin
         out_r.bit_tick <= run && tmr_wrap && pre_wrap && !(div_wr && pready);
         out_r.ovs_tick <= ovs_step && !(div_wr && pready);
      end
   end

   // three samples mid bit, then vote
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         smp_r <= 3'h7;
         out_r.smp_valid <= 1'b0;
         out_r.rx_level <= 1'b1;
      end else begin
         out_r.smp_valid <= 1'b0;
         if (out_r.ovs_tick) begin
            if (ovs_r == `UBRG_SMP_A) begin
               smp_r[0] <= receive_data_pin;
            end
            if (ovs_r == `UBRG_SMP_B) begin
               smp_r[1] <= receive_data_pin;
            end
            if (ovs_r == `UBRG_SMP_C) begin
               smp_r[2] <= receive_data_pin;
            end
            if (ovs_r == (`UBRG_SMP_C + 4'h1)) begin
               out_r.rx_level <= (smp_r[0] & smp_r[1]) | (smp_r[0] & smp_r[2])
                  | (smp_r[1] & smp_r[2]);
               out_r.smp_valid <= 1'b1;
            end
         end
      end
   end

   assign bit_tick = out_r.bit_tick;
   assign ovs_tick = out_r.ovs_tick;
   assign smp_valid = out_r.smp_valid;
   assign rx_level = out_r.rx_level;

   // ****************************************
   // tick spacing monitor for assertions
   // ****************************************
   // timer periods per bit for the current mode
   always_comb begin
      unique case (mode)
         UBRG_ASYNC_LOW: gap_fac = 16'(`UBRG_DIV_ASYNC_LOW) + 16'h0001;
         UBRG_ASYNC_HIGH: gap_fac = 16'(`UBRG_DIV_ASYNC_HIGH) + 16'h0001;
         UBRG_SYNC: gap_fac = 16'(`UBRG_DIV_SYNC) + 16'h0001;
         UBRG_OFF: gap_fac = 16'h0000;
      endcase
   end
   // whole bit period, factor times X+1
   assign gap_exp = gap_fac * (16'(baud_divisor_r) + 16'h0001);

   // clocks between ticks, spoilt by a divisor or control write
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gap_r <= 16'h0001;
         gap_ok_r <= 1'b0;
      end else begin
         // count restarts at each tick
         if (bit_tick) begin
            gap_r <= 16'h0001;
            gap_ok_r <= 1'b1;
         end else begin
            gap_r <= gap_r + 16'h0001;
         end
         // a write breaks the running period
         if ((div_wr || ctl_wr) && pready) begin
            gap_ok_r <= 1'b0;
         end
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   sequence s_div_write;
      psel && penable && pwrite && pready && (paddr == `UBRG_ADDR_DIVISOR);
   endsequence
   sequence s_div_read;
      psel && penable && !pwrite && pready && (paddr == `UBRG_ADDR_DIVISOR);
   endsequence

   AST_TICK_PERIOD: assert property (@(posedge clk) disable iff (!arst_n)
      (bit_tick && gap_ok_r) |-> (gap_r == gap_exp))
      else $error("bit tick spacing wrong");
   AST_DIV_READ: assert property (@(posedge clk) disable iff (!arst_n)
      s_div_read |-> (prdata[DIV_W-1:0] == baud_divisor_r))
      else $error("divisor read back wrong");
   AST_OVS_SYNC: assert property (@(posedge clk) disable iff (!arst_n)
      ctl_r.sync |=> !ovs_tick)
      else $error("oversample tick in sync mode");
   AST_OVS_HIGH: assert property (@(posedge clk) disable iff (!arst_n)
      ((mode == UBRG_ASYNC_HIGH) && tmr_wrap && !(div_wr && pready)) |=> ovs_tick)
      else $error("oversample tick missing in high speed");
   AST_BIT_ON_OVS: assert property (@(posedge clk) disable iff (!arst_n)
      (bit_tick && !$past(ctl_r.sync)) |-> ovs_tick)
      else $error("bit tick off oversample grid");
   AST_PRE_BOUND: assert property (@(posedge clk) disable iff (!arst_n)
      pre_r <= pre_last)
      else $error("prescaler past terminal");
   AST_OFF_IDLE: assert property (@(posedge clk) disable iff (!arst_n)
      (mode == UBRG_OFF) |=> (tmr_r == '0))
      else $error("timer runs while off");

   AST_TMR_RESTART: assert property (@(posedge clk) disable iff (!arst_n)
      s_div_write |=> (tmr_r == '0) && !bit_tick)
      else $error("timer not restarted by divisor write");
   AST_DIV_STORE: assert property (@(posedge clk) disable iff (!arst_n)
      s_div_write |=> (baud_divisor_r == $past(pwdata[DIV_W-1:0])))
      else $error("divisor not stored");
   AST_TMR_BOUND: assert property (@(posedge clk) disable iff (!arst_n)
      tmr_r <= baud_divisor_r)
      else $error("timer past divisor");
   AST_NO_RUN: assert property (@(posedge clk) disable iff (!arst_n)
      !ctl_r.master |=> !bit_tick)
      else $error("tick while not master");
   AST_SYNC_DIV: assert property (@(posedge clk) disable iff (!arst_n)
      (mode == UBRG_SYNC) |-> (pre_last == `UBRG_DIV_SYNC))
      else $error("sync divide wrong");
   AST_HSEL_IGN: assert property (@(posedge clk) disable iff (!arst_n)
      (ctl_r.master && ctl_r.sync) |-> (mode == UBRG_SYNC))
      else $error("hsel not ignored in sync");
   AST_ASYNC_HIGH: assert property (@(posedge clk) disable iff (!arst_n)
      (mode == UBRG_ASYNC_HIGH) |-> (pre_last == `UBRG_DIV_ASYNC_HIGH))
      else $error("async high divide wrong");
   AST_ASYNC_LOW: assert property (@(posedge clk) disable iff (!arst_n)
      (mode == UBRG_ASYNC_LOW) |-> (pre_last == `UBRG_DIV_ASYNC_LOW))
      else $error("async low divide wrong");
   AST_VOTE: assert property (@(posedge clk) disable iff (!arst_n)
      smp_valid |-> (rx_level == ((smp_r[0] & smp_r[1]) | (smp_r[0] & smp_r[2])
      | (smp_r[1] & smp_r[2]))))
      else $error("majority vote wrong");
   AST_TICK_SPACE: assert property (@(posedge clk) disable iff (!arst_n)
      (bit_tick && ctl_r.sync && (baud_divisor_r == '0) && !$changed(ctl_r))
      |=> !bit_tick [*3])
      else $error("sync tick spacing wrong");

endmodule

// File: dv/ubrg_peer.sv
`timescale 1ns/100ps
// ****************************************
// receive line and bit-period model
// ****************************************
module ubrg_peer (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic bit_tick,
   input wire logic level,
   input wire logic glitch,
   output logic receive_data_pin,
   output logic [15:0] period
);
   logic [15:0] cnt_r; // clocks since last tick
   logic [5:0] gl_r; // glitch phase counter
   // measure clocks between bit ticks
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= 16'h0001;
         period <= 16'h0000;
      end else if (bit_tick) begin
         cnt_r <= 16'h0001;
         period <= cnt_r;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end
   // free phase for the glitch
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gl_r <= 6'h00;
      end else begin
         gl_r <= (gl_r == 6'h2E) ? 6'h00 : gl_r + 6'h01;
      end
   end
   // one-clock glitch every 47 clocks, walks all phases
   assign receive_data_pin = (glitch && gl_r == 6'h00) ? !level : level;
endmodule

// File: dv/ubrg_top_bench.sv
`timescale 1ns/100ps
`include "ubrg_consts.svh"
// ****************************************
// bench top
// ****************************************
module ubrg_top_bench;
   import ubrg_pkg::*;
   logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, e, pin, bit_tick, ovs_tick, smp_valid, rx_level;
   logic level = 1, glitch = 0;
   logic [15:0] period;
   int error_cnt = 0, n_checks = 0, got, bad, nv;
   logic [7:0] ovs_cnt = 8'h00, ovs_per_bit = 8'h00;
   // high speed also tried at the smallest divisor
   logic [7:0] ctl_tab [7] = '{8'h80, 8'h84, 8'h90, 8'h94, 8'h84, 8'h90, 8'h90};
   logic [7:0] div_tab [7] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h00, 8'h00, 8'hFF};
   ubrg_mode_t mode_tab [7] = '{UBRG_ASYNC_LOW, UBRG_ASYNC_HIGH, UBRG_SYNC, UBRG_SYNC,
      UBRG_ASYNC_HIGH, UBRG_SYNC, UBRG_SYNC};
   ubrg_top u_ubrg_top (.clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .receive_data_pin(pin), .bit_tick(bit_tick),
      .ovs_tick(ovs_tick), .smp_valid(smp_valid), .rx_level(rx_level));
   ubrg_peer u_ubrg_peer (.clk(clk), .arst_n(arst_n), .bit_tick(bit_tick), .level(level),
      .glitch(glitch), .receive_data_pin(pin), .period(period));
   // oversample ticks per bit period
   always @(posedge clk) begin
      if (bit_tick) begin
         ovs_per_bit <= ovs_cnt + ovs_tick;
         ovs_cnt <= 8'h00;
      end else begin
         ovs_cnt <= ovs_cnt + ovs_tick;
      end
   end
   // 125 MHz clock
   initial begin
      forever #4 clk = ~clk;
   end
   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one apb transfer, waits for pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // clocks until a bit tick, bounded
   task automatic wait_tick(input int lim);
      got = 0;
      do begin
         @(posedge clk);
         got++;
      end while (bit_tick !== 1'b1 && got < lim);
   endtask
   // verdict and end of run
   task automatic final_report;
      if (error_cnt == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // hang guard
   initial begin
      #400000;
      error_cnt++;
      final_report;
   end
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1;
      chk(rx_level, 1);
      apb(0, `UBRG_ADDR_DIVISOR, 0);
      chk(q, 0);
      apb(0, `UBRG_ADDR_STATUS, 0);
      chk(q[9:8], UBRG_OFF);
      wait_tick(300);
      chk(got, 300);
      apb(0, 12'h00C, 0);
      chk(q, 32'h0);
      chk(e, 1);
      apb(1, `UBRG_ADDR_DIVISOR, 32'h1AB);
      apb(0, `UBRG_ADDR_DIVISOR, 0);
      chk(q, 32'hAB);
      chk(e, 0);
      for (int i = 0; i < 7; i++) begin
         apb(1, `UBRG_ADDR_CONTROL, ctl_tab[i]);
         apb(1, `UBRG_ADDR_DIVISOR, div_tab[i]);
         apb(0, `UBRG_ADDR_STATUS, 0);
         chk(q[9:8], mode_tab[i]);
         repeat (3) wait_tick(5000);
         @(negedge clk);
         chk(period, (div_tab[i] + 1) * (ctl_tab[i][4] ? 4 : ctl_tab[i][2] ? 16 : 64));
         chk(ovs_per_bit, ctl_tab[i][4] ? 0 : 16);
      end
      wait_tick(2000);
      repeat (100) @(posedge clk);
      apb(1, `UBRG_ADDR_DIVISOR, 32'h01);
      wait_tick(40);
      chk(got <= 12, 1);
      apb(1, `UBRG_ADDR_CONTROL, 8'h84);
      apb(1, `UBRG_ADDR_DIVISOR, 32'h00);
      level <= 0;
      repeat (200) @(posedge clk);
      chk(rx_level, 0);
      level <= 1;
      glitch <= 1;
      repeat (200) @(posedge clk);
      bad = 0;
      nv = 0;
      repeat (800) begin
         @(posedge clk);
         nv += (smp_valid === 1'b1);
         if (smp_valid === 1'b1 && rx_level !== 1'b1) begin
            bad++;
         end
      end
      chk(bad, 0);
      chk(nv, 50);
      final_report;
   end
endmodule
